// ---- hdl/aric_ctrl.sv ----
// Converter control: APB registers, conversion sequencer, SAR, interrupt.
// Assumes an external comparator answering "input at or above DAC code"
// and an analog multiplexer steered by chan_sel.
//
// Function
// - Reset restores registers, leaves converter powered down
// - Reset ends running conversion, clears complete flag
// - Reset clears the whole SAR register
// - Reset cancels any pending converter interrupt
// - Power-on bit enables without touching registers
// - Control write aborts conversion, nothing else reset
// - Enabled interrupt fires at end, results valid
// - With event mask clear, enabled interrupt pending exactly while complete flag set
// - Any status/control write clears complete flag
// - Reading either result byte clears flag
// - One of eight channels routed per conversion
// - Status/control write aborts, then starts conversion
// - Pin enable write aborts, starts nothing
// - Power-on clear stops clock, aborts conversion
// - Sampling window lasts fourteen conversion clocks
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps

module aric_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter core and multiplexer
  input  wire logic        comp_hi,
  output logic [2:0]       chan_sel,
  output logic             sample_en,
  output logic [9:0]       sar_code,
  output logic [7:0]       pin_enable,
  output logic             conv_busy,
  // Interrupt
  output logic             irq
);

  // ==========================================================
  // Reset release and comparator synchroniser
  logic rst_meta_r;
  logic rst_sync_b;
  logic comp_meta_r;
  logic comp_sync_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // The comparator answers the code set at the previous tick; the two
  // sync stages need a tick period of at least three bus clocks, so a
  // prescale of zero decides on a stale comparison.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      comp_meta_r <= 1'b0;
      comp_sync_r <= 1'b0;
    end else begin
      comp_meta_r <= comp_hi;
      comp_sync_r <= comp_meta_r;
    end
  end

  // ==========================================================
  // Register state
  aric_pkg::aric_ctrl_type   ctrl_r;
  aric_pkg::aric_result_type result_r;
  aric_pkg::aric_state_type  state_r;
  aric_pkg::aric_state_type  state_nxt;
  logic        ccf_r;
  logic        ie_r;
  logic [2:0]  chan_r;
  logic [7:0]  pin_en_r;
  logic [1:0]  evt_sts_r;
  logic [1:0]  evt_msk_r;
  logic [9:0]  sar_r;
  logic [3:0]  bit_r;
  logic [3:0]  samp_cnt_r;
  logic [4:0]  div_r;
  logic [31:0] prdata_r;

  // ==========================================================
  // APB decode
  wire setup_ph  = psel && !penable;
  wire access_ph = psel && penable;
  wire wr_acc    = access_ph && pwrite;
  wire rd_acc    = access_ph && !pwrite;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  wire sel_ctrl  = hit(paddr, aric_pkg::OFF_CTRL);
  wire sel_sc    = hit(paddr, aric_pkg::OFF_STATSC);
  wire sel_rhi   = hit(paddr, aric_pkg::OFF_RES_HI);
  wire sel_rlo   = hit(paddr, aric_pkg::OFF_RES_LO);
  wire sel_pe    = hit(paddr, aric_pkg::OFF_PIN_EN);
  wire sel_ests  = hit(paddr, aric_pkg::OFF_EVT_STS);
  wire sel_emsk  = hit(paddr, aric_pkg::OFF_EVT_MSK);
  wire mapped    = sel_ctrl | sel_sc | sel_rhi | sel_rlo | sel_pe
                 | sel_ests | sel_emsk;

  wire ctrl_wr   = wr_acc && sel_ctrl;
  wire sc_wr     = wr_acc && sel_sc;
  wire pe_wr     = wr_acc && sel_pe;
  wire ests_wr   = wr_acc && sel_ests;
  wire emsk_wr   = wr_acc && sel_emsk;
  wire res_rd    = rd_acc && (sel_rhi || sel_rlo);

  wire [7:0] sc_view = {ccf_r, ie_r, 3'h0, chan_r};

  wire [7:0] rd_mux =
      sel_ctrl ? ctrl_r :
      sel_sc   ? sc_view :
      sel_rhi  ? result_r.hi :
      sel_rlo  ? result_r.lo :
      sel_pe   ? pin_en_r :
      sel_ests ? {6'h00, evt_sts_r} :
      sel_emsk ? {6'h00, evt_msk_r} : 8'h00;

  assign pready  = access_ph;
  assign pslverr = access_ph && !mapped;
  assign prdata  = prdata_r;

  // Read data is captured in the setup cycle so it leaves a flop.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= {24'h00_0000, rd_mux};
    end
  end

  // ==========================================================
  // Conversion clock prescaler: divide by (prescale + 1) * 2
  wire [4:0] div_lim = {ctrl_r.prescale, 1'b1};
  wire       powered = ctrl_r.power_on;
  wire       running = (state_r != aric_pkg::ST_IDLE);
  wire       tick    = powered && running && (div_r == div_lim);

  // ==========================================================
  // Sequencer
  wire abort    = ctrl_wr || pe_wr || sc_wr || !powered;
  wire start    = sc_wr && powered;
  wire samp_end = tick && (state_r == aric_pkg::ST_SAMPLE)
               && (samp_cnt_r == aric_pkg::SAMPLE_TICKS - 4'h1);
  wire last_bit = tick && (state_r == aric_pkg::ST_CONVERT)
               && (bit_r == 4'h0);
  wire done     = last_bit && !abort;
  wire aborted  = running && abort;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      aric_pkg::ST_IDLE: begin
        if (start) begin
          state_nxt = aric_pkg::ST_SAMPLE;
        end
      end
      aric_pkg::ST_SAMPLE: begin
        if (start) begin
          state_nxt = aric_pkg::ST_SAMPLE;
        end else if (abort) begin
          state_nxt = aric_pkg::ST_IDLE;
        end else if (samp_end) begin
          state_nxt = aric_pkg::ST_CONVERT;
        end
      end
      aric_pkg::ST_CONVERT: begin
        if (start) begin
          state_nxt = aric_pkg::ST_SAMPLE;
        end else if (abort || last_bit) begin
          state_nxt = aric_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = aric_pkg::ST_IDLE;
      end
    endcase
  end

  // Trial bit decision: keep the bit when the input is at or above it.
  wire [9:0] bit_mask = 10'h001 << bit_r;
  wire [9:0] sar_kept = comp_sync_r ? sar_r : (sar_r & ~bit_mask);
  wire [9:0] sar_next = sar_kept | (bit_mask >> 1);

  // Result formatting per resolution, justification and sign.
  function automatic aric_pkg::aric_result_type fmt(
      input logic [9:0] d, input aric_pkg::aric_ctrl_type c);
    logic [9:0] s;
    s = d;
    if (c.signed_res && !c.right_just) begin
      s[9] = ~d[9];
    end
    if (c.res8) begin
      fmt = {s[9:2], 8'h00};
    end else if (c.right_just) begin
      fmt = {6'h00, d};
    end else begin
      fmt = {s, 6'h00};
    end
  endfunction : fmt

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_r    <= aric_pkg::ST_IDLE;
      sar_r      <= aric_pkg::SAR_RST;
      bit_r      <= aric_pkg::RESULT_MSB;
      samp_cnt_r <= 4'h0;
      div_r      <= 5'h00;
    end else begin
      state_r <= state_nxt;
      if (start || !running || !powered) begin
        div_r <= 5'h00;
      end else if (tick) begin
        div_r <= 5'h00;
      end else begin
        div_r <= div_r + 5'h01;
      end
      if (start) begin
        samp_cnt_r <= 4'h0;
        bit_r      <= aric_pkg::RESULT_MSB;
        sar_r      <= aric_pkg::SAR_FIRST_TRY;
      end else if (samp_end && !abort) begin
        samp_cnt_r <= 4'h0;
      end else if (tick && state_r == aric_pkg::ST_SAMPLE) begin
        samp_cnt_r <= samp_cnt_r + 4'h1;
      end else if (tick && state_r == aric_pkg::ST_CONVERT && !abort) begin
        sar_r <= last_bit ? sar_kept : sar_next;
        bit_r <= bit_r - 4'h1;
      end
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_r    <= aric_pkg::CTRL_RST;
      ie_r      <= 1'b0;
      chan_r    <= 3'h0;
      pin_en_r  <= aric_pkg::PIN_EN_RST;
      evt_msk_r <= aric_pkg::EVT_MSK_RST;
      result_r  <= 16'h0000;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= pwdata[7:0];
      end
      if (sc_wr) begin
        ie_r   <= pwdata[aric_pkg::STATSC_IE_BIT];
        chan_r <= pwdata[2:0];
      end
      if (pe_wr) begin
        pin_en_r <= pwdata[7:0];
      end
      if (emsk_wr) begin
        evt_msk_r <= pwdata[1:0];
      end
      if (done) begin
        result_r <= fmt(sar_kept, ctrl_r);
      end
    end
  end

  // Complete flag: a finishing conversion wins over a result read.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ccf_r <= 1'b0;
    end else if (done) begin
      ccf_r <= 1'b1;
    end else if (sc_wr || res_rd) begin
      ccf_r <= 1'b0;
    end
  end

  // Sticky events, write one to clear; set beats clear.
  wire [1:0] evt_set = {aborted, done};
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      evt_sts_r <= 2'h0;
    end else begin
      evt_sts_r <= (evt_sts_r & ~(ests_wr ? pwdata[1:0] : 2'h0)) | evt_set;
    end
  end

  // ==========================================================
  // Outputs
  wire irq_ccf = ccf_r && ie_r;
  assign irq        = irq_ccf || |(evt_sts_r & evt_msk_r);
  assign chan_sel   = chan_r;
  assign sample_en  = (state_r == aric_pkg::ST_SAMPLE);
  assign sar_code   = sar_r;
  assign pin_enable = pin_en_r;
  assign conv_busy  = running;

  // ==========================================================
  // Checks
  AST_RESET_STATE: assert property (@(posedge clk)
    !rst_sync_b |-> (!ctrl_r.power_on && !ccf_r && !running))
    else $error("Reset left converter powered or busy");
  AST_RESET_SAR: assert property (@(posedge clk)
    !rst_sync_b |-> (sar_r == 10'h000 && !irq))
    else $error("Reset left SAR bits or interrupt set");
  AST_IRQ_FOLLOWS_CCF: assert property (@(posedge clk)
    disable iff (!rst_sync_b)
    (evt_msk_r == 2'h0) |-> (irq == (ccf_r && ie_r)))
    else $error("Interrupt does not track complete flag");
  AST_SC_CLEARS: assert property (@(posedge clk)
    disable iff (!rst_sync_b) sc_wr |=> !ccf_r)
    else $error("Status write did not clear flag");
  AST_READ_CLEARS: assert property (@(posedge clk)
    disable iff (!rst_sync_b) (res_rd && !done) |=> !ccf_r)
    else $error("Result read did not clear flag");
  AST_CTRL_ABORT: assert property (@(posedge clk)
    disable iff (!rst_sync_b)
    (ctrl_wr || pe_wr) |=> (state_r == aric_pkg::ST_IDLE && $stable(ie_r)))
    else $error("Control or pin write did not abort");
  AST_SC_START: assert property (@(posedge clk)
    disable iff (!rst_sync_b)
    start |=> (state_r == aric_pkg::ST_SAMPLE && samp_cnt_r == 4'h0))
    else $error("Status write did not start sampling");
  AST_POWER_OFF: assert property (@(posedge clk)
    disable iff (!rst_sync_b)
    !powered |=> (!running && !tick))
    else $error("Powered down converter kept running");
  AST_SAMPLE_LEN: assert property (@(posedge clk)
    disable iff (!rst_sync_b)
    (samp_end && !abort) |-> (samp_cnt_r == 4'hD)
      ##1 (state_r == aric_pkg::ST_CONVERT))
    else $error("Sampling window not fourteen ticks");
  AST_DONE_RESULT: assert property (@(posedge clk)
    disable iff (!rst_sync_b)
    done |=> (ccf_r && result_r == fmt($past(sar_kept), ctrl_r)))
    else $error("Completion without result or flag");
  AST_CHAN_STABLE: assert property (@(posedge clk)
    disable iff (!rst_sync_b)
    (running && $past(running) && !$past(sc_wr)) |-> $stable(chan_sel))
    else $error("Channel changed mid conversion");
  AST_POWER_KEEPS: assert property (@(posedge clk)
    disable iff (!rst_sync_b)
    $rose(ctrl_r.power_on) |-> ($stable(result_r) && $stable(chan_r)))
    else $error("Power up disturbed registers");

endmodule : aric_ctrl

// ---- hdl/aric_pkg.sv ----
// Shared constants and carrier types for the converter control block.
// Assumes a 32-bit APB master and one 20 MHz bus clock.
package aric_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATSC  = 8'h04;
  localparam logic [7:0] OFF_RES_HI  = 8'h08;
  localparam logic [7:0] OFF_RES_LO  = 8'h0C;
  localparam logic [7:0] OFF_PIN_EN  = 8'h10;
  localparam logic [7:0] OFF_EVT_STS = 8'h14;
  localparam logic [7:0] OFF_EVT_MSK = 8'h18;

  // ==========================================================
  // Field positions
  localparam int STATSC_CCF_BIT = 7;
  localparam int STATSC_IE_BIT  = 6;
  localparam int EVT_DONE_BIT   = 0;
  localparam int EVT_ABORT_BIT  = 1;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] PIN_EN_RST  = 8'h00;
  localparam logic [1:0] EVT_MSK_RST = 2'h0;
  localparam logic [9:0] SAR_RST     = 10'h000;

  // ==========================================================
  // Timing
  localparam int          CLK_HZ         = 20_000_000;
  localparam logic [3:0]  SAMPLE_TICKS   = 4'hE;
  localparam logic [3:0]  RESULT_MSB     = 4'h9;
  localparam logic [9:0]  SAR_FIRST_TRY  = 10'h200;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic       power_on;
    logic       right_just;
    logic       res8;
    logic       signed_res;
    logic [3:0] prescale;
  } aric_ctrl_type;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } aric_result_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } aric_state_type;

endpackage : aric_pkg

// ---- test/aric_adc_model.sv ----
// Analog side stand-in: eight channel levels, input mux, sample/hold and
// an ideal comparator against the trial code.
// Assumes the control block resynchronises comp_hi itself.
`timescale 1ns/1ps

module aric_adc_model (
  // Clock
  input  wire logic            clk,
  // Channel levels set by the bench
  input  wire logic [7:0][9:0] level,
  // Control side
  input  wire logic [2:0]      chan_sel,
  input  wire logic            sample_en,
  input  wire logic [9:0]      sar_code,
  output logic                 comp_hi
);
  logic [9:0] held_r = 10'h000;

  // Only one channel reaches the hold node, and only inside the window
  always_ff @(posedge clk) begin
    if (sample_en) begin
      held_r <= level[chan_sel];
    end
  end

  assign comp_hi = (held_r >= sar_code);
endmodule : aric_adc_model

// ---- test/tb.sv ----
// Self-checking bench for the converter control block.
// Assumes aric_adc_model as analog side; the bench is the APB master.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module tb;
  logic            clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]      paddr, pin_enable, ctl, a1;
  logic [31:0]     pwdata, prdata, rd;
  logic            comp_hi, sample_en, conv_busy, irq;
  logic [2:0]      chan_sel;
  logic [9:0]      sar_code;
  logic [7:0][9:0] level;
  logic [15:0]     seed, e;
  int              fail_count, num_checks, cyc, samp;

  aric_ctrl aric_ctrl_i (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_hi(comp_hi), .chan_sel(chan_sel), .sample_en(sample_en),
    .sar_code(sar_code), .pin_enable(pin_enable), .conv_busy(conv_busy),
    .irq(irq));
  aric_adc_model aric_adc_model_i (.clk(clk), .level(level),
    .chan_sel(chan_sel), .sample_en(sample_en), .sar_code(sar_code),
    .comp_hi(comp_hi));

  // ==========================================================
  // Clock, window counter, hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Negative edge keeps the counter clear of the design's own updates
  always @(negedge clk) begin
    cyc++;
    if (sample_en === 1'b1) begin
      samp++;
    end
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Left-justified signed results flip the msb; 8-bit results sit high
  function automatic logic [15:0] fmt(input logic [7:0] c,
                                      input logic [9:0] d);
    logic [9:0] v;
    v = d ^ {c[4] && !c[6], 9'h000};
    if (c[5]) begin
      return {v[9:2], 8'h00};
    end
    return c[6] ? {6'h00, d} : {v, 6'h00};
  endfunction : fmt

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench's cycle ceiling ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    `CHK(rd, {24'h00_0000, x})
    `CHK(err, 1'b0)
  endtask : rchk

  task automatic wait_done(input logic ie);
    int n;
    n = 0;
    rd = 32'h0000_0000;
    while (n < 400 && (ie ? irq !== 1'b1 : rd[7] !== 1'b1)) begin
      if (ie) begin
        @(negedge clk);
      end else begin
        apb(1'b0, aric_pkg::OFF_STATSC, 8'h00);
      end
      n++;
    end
  endtask : wait_done

  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    @(negedge clk);
    `CHK({irq, conv_busy, sar_code}, 12'h000)
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic start(input logic [7:0] c, input logic [7:0] s);
    apb(1'b1, aric_pkg::OFF_CTRL, c);
    samp = 0;
    apb(1'b1, aric_pkg::OFF_STATSC, s);
  endtask : start

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Main sequence
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {fail_count, num_checks, cyc, samp} = '0;
    level = '0;
    seed  = 16'h3FFA;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK({irq, conv_busy, sample_en, sar_code}, 13'h0000)
    rchk(aric_pkg::OFF_CTRL, aric_pkg::CTRL_RST);
    rchk(aric_pkg::OFF_STATSC, 8'h00);
    apb(1'b0, 8'h1C, 8'h00);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, aric_pkg::OFF_PIN_EN, 8'hA5);
    apb(1'b1, aric_pkg::OFF_CTRL, 8'hC1);
    rchk(aric_pkg::OFF_PIN_EN, 8'hA5);
    `CHK(pin_enable, 8'hA5)
    // Every channel and result format, irq and polled completion
    for (int ch = 0; ch < 8; ch++) begin
      seed = lfsr(seed);
      level[ch] <= (ch == 0) ? 10'h000 : (ch == 7) ? 10'h3FF : seed[9:0];
      ctl = ch[0] ? 8'hC1 : {2'b10, ch[2:1], 4'b0001};
      start(ctl, {1'b0, ch[1], 3'b000, ch[2:0]});
      wait_done(ch[1]);
      `CHK(chan_sel, ch[2:0])
      `CHK(samp, 14 * 4)
      repeat (5) @(posedge clk);
      #1;
      `CHK(irq, ch[1])
      e  = fmt(ctl, level[ch]);
      a1 = ch[0] ? aric_pkg::OFF_RES_HI : aric_pkg::OFF_RES_LO;
      rchk(a1, ch[0] ? e[15:8] : e[7:0]);
      `CHK(irq, 1'b0)
      rchk(aric_pkg::OFF_STATSC, {1'b0, ch[1], 3'b000, ch[2:0]});
      rchk(a1 ^ 8'h04, ch[0] ? e[7:0] : e[15:8]);
    end
    // Restart while complete: flag drops, new conversion runs
    start(8'hC1, 8'h40);
    wait_done(1'b1);
    apb(1'b1, aric_pkg::OFF_STATSC, 8'h40);
    `CHK({irq, conv_busy}, 2'b01)
    // Abort by control write, pin enable write, power-off
    for (int k = 0; k < 3; k++) begin
      start(8'hC1, 8'h40);
      repeat (20) @(posedge clk);
      ctl = (k == 2) ? 8'h41 : 8'hC1;
      apb(1'b1, (k == 1) ? aric_pkg::OFF_PIN_EN : aric_pkg::OFF_CTRL, ctl);
      repeat (2) @(posedge clk);
      #1;
      `CHK({conv_busy, sample_en}, 2'b00)
      repeat (150) @(posedge clk);
      #1;
      `CHK({irq, conv_busy}, 2'b00)
    end
    rchk(aric_pkg::OFF_CTRL, 8'h41);
    rchk(aric_pkg::OFF_PIN_EN, 8'hC1);
    rchk(aric_pkg::OFF_EVT_STS, 8'h03);
    apb(1'b1, aric_pkg::OFF_EVT_MSK, 8'h02);
    `CHK(irq, 1'b1)
    apb(1'b1, aric_pkg::OFF_EVT_STS, 8'h03);
    `CHK(irq, 1'b0)
    apb(1'b1, aric_pkg::OFF_EVT_MSK, 8'h00);
    // Reset with a pending request, then in mid-conversion
    start(8'hC1, 8'h40);
    wait_done(1'b1);
    do_reset();
    rchk(aric_pkg::OFF_STATSC, 8'h00);
    start(8'hC1, 8'h40);
    repeat (30) @(posedge clk);
    do_reset();
    rchk(aric_pkg::OFF_CTRL, aric_pkg::CTRL_RST);
    rchk(aric_pkg::OFF_PIN_EN, aric_pkg::PIN_EN_RST);
    `CHK({conv_busy, irq}, 2'b00)
    report_and_stop();
  end
endmodule : tb
